//--- rtl/tlw_pkg.sv
/*
  Package for the translation entry low word block: register offsets, field
  positions inside the low word, zone codes, access kinds and reset values.
  Assumes bit 0 of every field below is the least significant bit.
*/
package tlw_pkg;

  // Avalon-MM byte offsets, one aligned word each
  localparam logic [4:0] OFS_LOW_WORD  = 5'h00;
  localparam logic [4:0] OFS_INDEX     = 5'h04;
  localparam logic [4:0] OFS_ZONE      = 5'h08;
  localparam logic [4:0] OFS_IRQ_STAT  = 5'h0C;
  localparam logic [4:0] OFS_IRQ_CLR   = 5'h10;
  localparam logic [4:0] OFS_IRQ_EN    = 5'h14;

  // Low word field positions (LSB numbering)
  localparam int PAGE_MSB      = 31;
  localparam int PAGE_LSB      = 10;
  localparam int EXEC_BIT      = 9;
  localparam int WRITE_BIT     = 8;
  localparam int ZONE_MSB      = 7;
  localparam int ZONE_LSB      = 4;
  localparam int WTHRU_BIT     = 3;
  localparam int INHIBIT_BIT   = 2;
  localparam int COHERENT_BIT  = 1;
  localparam int GUARD_BIT     = 0;

  // Page size field: offset bits = base + step * size
  localparam int SIZE_BASE_SHIFT = 10;
  localparam int SIZE_STEP_SHIFT = 2;
  localparam int ZONE_FIELD_W    = 2;
  localparam int ZONE_COUNT      = 16;

  // Translation mode value that enables full virtual translation
  localparam int MODE_VIRTUAL = 3;

  // Zone override codes
  localparam logic [1:0] ZONE_CODE_00 = 2'h0;
  localparam logic [1:0] ZONE_CODE_01 = 2'h1;
  localparam logic [1:0] ZONE_CODE_10 = 2'h2;
  localparam logic [1:0] ZONE_CODE_11 = 2'h3;

  // Access kinds presented by the pipeline
  localparam logic [1:0] KIND_FETCH = 2'h0;
  localparam logic [1:0] KIND_LOAD  = 2'h1;
  localparam logic [1:0] KIND_STORE = 2'h2;

  // Interrupt status bit positions
  localparam int IRQ_ISI  = 0;
  localparam int IRQ_DSI  = 1;
  localparam int IRQ_DENY = 2;
  localparam int IRQ_W    = 3;

  // Configuration-load contents of an entry
  localparam logic [31:0] ENTRY_INIT    = 32'h0000_0000;
  localparam logic [31:0] WTHRU_MASK    = 32'h0000_0008;
  localparam logic [31:0] COHERENT_MASK = 32'h0000_0002;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

endpackage

//--- rtl/tlw_zone_check.sv
/*
  Zone override of an entry's permissions. Purely combinational; the caller
  registers the results. Assumes the zone code is already picked out of the
  zone override register by the entry's zone select field.
*/
`timescale 1ns/1ps
module tlw_zone_check
  import tlw_pkg::*;
(
  input  wire logic       i_user,
  input  wire logic [1:0] i_zone_code,
  input  wire logic       i_entry_valid,
  input  wire logic       i_entry_exec,
  input  wire logic       i_entry_write,
  output logic            o_allow,
  output logic            o_exec_ok,
  output logic            o_write_ok
);

  // User mode: 00 denies all, 11 grants; privileged: 10 and 11 grant
  always_comb
  begin
    o_allow    = i_entry_valid;
    o_exec_ok  = i_entry_exec;
    o_write_ok = i_entry_write;
    if (i_user && (i_zone_code == ZONE_CODE_00))
    begin
      o_allow    = 1'b0;
      o_exec_ok  = 1'b0;
      o_write_ok = 1'b0;
    end
    else if ((i_zone_code == ZONE_CODE_11) ||
             (!i_user && (i_zone_code == ZONE_CODE_10)))
    begin
      o_exec_ok  = 1'b1;
      o_write_ok = 1'b1;
    end
  end

endmodule

//--- rtl/tlw_top.sv
/*
  Low word of the unified translation buffer entries with the attribute and
  permission check that follows a hit. Software reaches the entries through
  an Avalon-MM slave; the pipeline presents one lookup per cycle at most and
  gets the physical address, faults and storage attributes one cycle later.
  Assumes the tag compare (high word) is done outside and hands in the hit
  entry number, its page size and its valid bit.
*/
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module tlw_top
  import tlw_pkg::*;
#(
  parameter int translation_mode_param  = MODE_VIRTUAL,
  parameter bit writeback_cache_param   = 1'b0,
  parameter int ENTRIES                 = 64,
  parameter int IDX_W                   = 6
)
(
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]       i_avs_address,
  input  wire logic             i_avs_read,
  input  wire logic             i_avs_write,
  input  wire logic [31:0]      i_avs_writedata,
  input  wire logic [3:0]       i_avs_byteenable,
  output logic [31:0]           o_avs_readdata,
  output logic                  o_avs_waitrequest,
  // Lookup from the pipeline
  input  wire logic             i_lk_valid,
  input  wire logic [1:0]       i_lk_kind,
  input  wire logic             i_lk_spec,
  input  wire logic             i_lk_user,
  input  wire logic [31:0]      i_lk_vaddr,
  input  wire logic [IDX_W-1:0] i_lk_entry,
  input  wire logic [2:0]       i_lk_size,
  input  wire logic             i_lk_entry_valid,
  // Lookup result
  output logic                  o_lk_done,
  output logic [31:0]           o_lk_paddr,
  output logic                  o_lk_isi,
  output logic                  o_lk_dsi,
  output logic                  o_lk_cache_inhibit,
  output logic                  o_lk_write_thru,
  output logic                  o_lk_guarded,
  output logic                  o_lk_spec_block,
  output logic                  o_irq
);

  localparam bit VIRT_MODE = (translation_mode_param == MODE_VIRTUAL);

  // Entry array; no reset port touches it, the configuration load and low word bus writes set it
  localparam logic [31:0] ENTRY_LOAD = writeback_cache_param ? (ENTRY_INIT & ~COHERENT_MASK) :
                                       ((ENTRY_INIT & ~COHERENT_MASK) | WTHRU_MASK);
  logic [31:0]      entry_mem [ENTRIES] = '{default: ENTRY_LOAD};
  logic [IDX_W-1:0] index_reg;
  logic [31:0]      zone_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [31:0]      wdata_merged;
  logic [31:0]      wdata_fixed;
  logic [31:0]      sel_entry;
  logic [31:0]      rdata_next;
  logic             bus_req;
  logic             bus_take;
  logic             bus_wr;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  // Merge the written byte lanes into an old word
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  be);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Fixed bits of a stored word: coherence zero, write-through forced when no write-back
  function automatic logic [31:0] fix_word(input logic [31:0] w);
    logic [31:0] res;
    res = w & ~COHERENT_MASK;
    if (!writeback_cache_param)
    begin
      res = res | WTHRU_MASK;
    end
    return res;
  endfunction

  // One wait cycle, then a single-cycle answer; writes land on the answer edge,
  // the only edge at which the master knows the transfer completed
  assign bus_req      = i_avs_read || i_avs_write;
  assign bus_take     = bus_req && o_avs_waitrequest;
  assign bus_wr       = i_avs_write && !o_avs_waitrequest;
  assign sel_entry    = entry_mem[index_reg];
  assign wdata_merged = merge_lanes(sel_entry, i_avs_writedata, i_avs_byteenable);
  assign wdata_fixed  = fix_word(wdata_merged);

  // Low word writes go to the indexed entry
  always_ff @(posedge i_mclk)
  begin
    if (bus_wr && (i_avs_address == OFS_LOW_WORD))
    begin
      entry_mem[index_reg] <= wdata_fixed;
    end
  end

  // Index and zone override registers
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      index_reg <= '0;
      zone_reg  <= ZERO_WORD;
    end
    else if (bus_wr)
    begin
      if (i_avs_address == OFS_INDEX)
      begin
        index_reg <= IDX_W'(merge_lanes(32'(index_reg), i_avs_writedata, i_avs_byteenable));
      end
      if (i_avs_address == OFS_ZONE)
      begin
        zone_reg <= merge_lanes(zone_reg, i_avs_writedata, i_avs_byteenable);
      end
    end
  end

  // Read mux; unmapped offsets and the clear register read as zero
  always_comb
  begin
    rdata_next = ZERO_WORD;
    case (i_avs_address)
      OFS_LOW_WORD: rdata_next = sel_entry;
      OFS_INDEX:    rdata_next = 32'(index_reg);
      OFS_ZONE:     rdata_next = zone_reg;
      OFS_IRQ_STAT: rdata_next = 32'(irq_stat_reg);
      OFS_IRQ_EN:   rdata_next = 32'(irq_en_reg);
      default:      rdata_next = ZERO_WORD;
    endcase
  end

  // Bus answer: waitrequest drops for exactly one cycle per request
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= ZERO_WORD;
    end
    else
    begin
      o_avs_waitrequest <= !bus_take;
      if (bus_take && i_avs_read)
      begin
        o_avs_readdata <= rdata_next;
      end
    end
  end

  // Lookup path
  logic [31:0] hit_word;
  logic [1:0]  zone_code;
  logic        zc_allow;
  logic        zc_exec;
  logic        zc_write;
  logic [4:0]  off_bits;
  logic [31:0] off_mask;
  logic [31:0] paddr_next;
  logic        isi_next;
  logic        dsi_next;
  logic        deny_next;

  assign hit_word  = entry_mem[i_lk_entry];
  // Zone n sits in the two bits counted from the top of the register
  assign zone_code = zone_reg[(ZONE_COUNT - 1 - 32'(hit_word[ZONE_MSB:ZONE_LSB])) * ZONE_FIELD_W
                              +: ZONE_FIELD_W];

  tlw_zone_check u_zone
  (
    .i_user        (i_lk_user),
    .i_zone_code   (zone_code),
    .i_entry_valid (i_lk_entry_valid),
    .i_entry_exec  (hit_word[EXEC_BIT]),
    .i_entry_write (hit_word[WRITE_BIT]),
    .o_allow       (zc_allow),
    .o_exec_ok     (zc_exec),
    .o_write_ok    (zc_write)
  );

  // Unused low page number bits are dropped even if software left them set
  always_comb
  begin
    off_bits = 5'(SIZE_BASE_SHIFT + SIZE_STEP_SHIFT * 32'(i_lk_size));
    off_mask = ~(32'hFFFF_FFFF << off_bits);
    paddr_next = i_lk_vaddr;
    if (VIRT_MODE)
    begin
      paddr_next = ({hit_word[PAGE_MSB:PAGE_LSB], 10'h000} & ~off_mask) |
                   (i_lk_vaddr & off_mask);
    end
  end

  // Faults: zone denial shows as the fault of the access kind
  assign deny_next = !zc_allow;
  assign isi_next  = (i_lk_kind == KIND_FETCH) && (deny_next || !zc_exec);
  assign dsi_next  = (i_lk_kind != KIND_FETCH) &&
                     (deny_next || ((i_lk_kind == KIND_STORE) && !zc_write));

  // Registered lookup answer, one cycle after the request
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_lk_done          <= 1'b0;
      o_lk_paddr         <= ZERO_WORD;
      o_lk_isi           <= 1'b0;
      o_lk_dsi           <= 1'b0;
      o_lk_cache_inhibit <= 1'b0;
      o_lk_write_thru    <= 1'b0;
      o_lk_guarded       <= 1'b0;
      o_lk_spec_block    <= 1'b0;
    end
    else
    begin
      o_lk_done          <= i_lk_valid;
      o_lk_paddr         <= paddr_next;
      o_lk_isi           <= i_lk_valid && isi_next;
      o_lk_dsi           <= i_lk_valid && dsi_next;
      o_lk_cache_inhibit <= hit_word[INHIBIT_BIT];
      o_lk_write_thru    <= hit_word[WTHRU_BIT] || !writeback_cache_param;
      o_lk_guarded       <= hit_word[GUARD_BIT];
      o_lk_spec_block    <= i_lk_valid && i_lk_spec && hit_word[GUARD_BIT];
    end
  end

  // Sticky status: a set in the clearing cycle survives
  assign irq_set = {i_lk_valid && deny_next, i_lk_valid && dsi_next, i_lk_valid && isi_next};
  assign irq_clr = (bus_wr && (i_avs_address == OFS_IRQ_CLR)) ?
                   i_avs_writedata[IRQ_W-1:0] : '0;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      irq_stat_reg <= '0;
    end
    else
    begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end

  // Enable register and level interrupt
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      irq_en_reg <= '0;
      o_irq      <= 1'b0;
    end
    else
    begin
      if (bus_wr && (i_avs_address == OFS_IRQ_EN))
      begin
        irq_en_reg <= i_avs_writedata[IRQ_W-1:0];
      end
      o_irq <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_en_reg);
    end
  end

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  sequence bus_asked_s;
    bus_req && o_avs_waitrequest;
  endsequence

  sequence bus_answered_s;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence

  bus_answer_a: assert property (bus_asked_s |=> bus_answered_s)
    else $error("bus request not answered in one cycle");

  page_join_a: assert property (VIRT_MODE && i_lk_valid && (i_lk_size == 3'h0)
    |=> o_lk_paddr == {$past(hit_word[PAGE_MSB:PAGE_LSB]), $past(i_lk_vaddr[9:0])})
    else $error("physical address not built from page number");

  page_mask_a: assert property (i_lk_valid && (i_lk_size == 3'h7)
    |=> o_lk_paddr[23:0] == $past(i_lk_vaddr[23:0]))
    else $error("unused page number bits leaked into address");

  bypass_mode_a: assert property (!VIRT_MODE && i_lk_valid
    |=> o_lk_paddr == $past(i_lk_vaddr))
    else $error("page number used outside virtual mode");

  fetch_perm_a: assert property (i_lk_valid && (i_lk_kind == KIND_FETCH) && i_lk_entry_valid
    && !hit_word[EXEC_BIT] && (zone_code == ZONE_CODE_01) |=> o_lk_isi)
    else $error("fetch from non-executable page not faulted");

  store_perm_a: assert property (i_lk_valid && (i_lk_kind == KIND_STORE) && i_lk_entry_valid
    && !hit_word[WRITE_BIT] && (zone_code == ZONE_CODE_01) |=> o_lk_dsi)
    else $error("store to read-only page not faulted");

  zone_deny_a: assert property (i_lk_valid && i_lk_user && (zone_code == ZONE_CODE_00)
    |=> (o_lk_isi || o_lk_dsi) ##1 irq_stat_reg[IRQ_DENY])
    else $error("user zone 00 did not deny access");

  zone_grant_a: assert property (i_lk_valid && i_lk_entry_valid && !i_lk_user
    && (zone_code == ZONE_CODE_10) |=> !o_lk_isi && !o_lk_dsi)
    else $error("privileged zone 10 did not grant access");

  wthru_fixed_a: assert property (!writeback_cache_param && o_lk_done
    |-> o_lk_write_thru)
    else $error("write-back used without write-back option");

  coherent_zero_a: assert property (bus_take && i_avs_read
    && (i_avs_address == OFS_LOW_WORD) |=> !o_avs_readdata[COHERENT_BIT])
    else $error("coherence bit read as one");

  guard_spec_a: assert property (i_lk_valid && i_lk_spec
    |=> o_lk_spec_block == $past(hit_word[GUARD_BIT]))
    else $error("speculative access to guarded page allowed");

  irq_level_a: assert property ($rose(o_irq) |-> |($past(irq_stat_reg) | $past(irq_set)))
    else $error("interrupt without status");

endmodule

//--- sim/tlw_pipe_model.sv
/*
  Pipeline side model: presents one translated lookup at a time to the
  attribute check. Assumes the caller enters lookup just after a rising edge
  and samples the results when the task returns.
*/
`timescale 1ns/1ps
module tlw_pipe_model
#(
  parameter int IDX_W = 6
)
(
  input  wire logic             i_mclk,
  output logic                  o_lk_valid,
  output logic [1:0]            o_lk_kind,
  output logic                  o_lk_spec,
  output logic                  o_lk_user,
  output logic [31:0]           o_lk_vaddr,
  output logic [IDX_W-1:0]      o_lk_entry,
  output logic [2:0]            o_lk_size,
  output logic                  o_lk_entry_valid
);
  initial
  begin
    o_lk_valid       = 1'b0;
    o_lk_kind        = 2'h0;
    o_lk_spec        = 1'b0;
    o_lk_user        = 1'b0;
    o_lk_vaddr       = 32'h0000_0000;
    o_lk_entry       = '0;
    o_lk_size        = 3'h0;
    o_lk_entry_valid = 1'b0;
  end

  // One request for one cycle; results stand from the next edge and are read at
  // the falling edge after it, so the caller must wait for a rising edge again
  task automatic lookup(input logic [1:0] k, input logic sp, input logic u,
                        input logic [31:0] va, input logic [IDX_W-1:0] e,
                        input logic [2:0] sz, input logic ev);
    o_lk_valid       <= 1'b1;
    o_lk_kind        <= k;
    o_lk_spec        <= sp;
    o_lk_user        <= u;
    o_lk_vaddr       <= va;
    o_lk_entry       <= e;
    o_lk_size        <= sz;
    o_lk_entry_valid <= ev;
    @(posedge i_mclk);
    o_lk_valid       <= 1'b0;
    o_lk_vaddr       <= ~va; // Address wanders, so a stale value is never reused
    o_lk_entry_valid <= ~ev;
    @(negedge i_mclk);
  endtask
endmodule

//--- sim/tlw_top_tb.sv
/*
  Self-checking bench for the translation entry low word block. Drives the
  Avalon-MM slave directly and the lookup port through the pipeline model.
  Assumes the default parameters: virtual mode, no write-back cache option.
  A second instance runs outside virtual mode with the write-back option.
*/
`timescale 1ns/1ps
module tlw_top_tb
  import tlw_pkg::*;
;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic        rd_q = 1'b0;
  logic        wr_q = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic        wait_q;
  logic        lv, ls, lu, lev, done, isi, dsi, ci, wt, gd, sb, irq;
  logic [1:0]  lk;
  logic [31:0] lva, pa;
  logic [31:0] rdat2, pa2;
  logic        wt2;
  logic [5:0]  le;
  logic [2:0]  lsz;
  logic [31:0] seed = 32'h5e95;
  int          fails = 0;
  int          tests_run = 0;

  always #12.5 i_mclk = ~i_mclk;

  tlw_top dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_avs_address(adr),
    .i_avs_read(rd_q), .i_avs_write(wr_q), .i_avs_writedata(wdat),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdat), .o_avs_waitrequest(wait_q),
    .i_lk_valid(lv), .i_lk_kind(lk), .i_lk_spec(ls), .i_lk_user(lu),
    .i_lk_vaddr(lva), .i_lk_entry(le), .i_lk_size(lsz), .i_lk_entry_valid(lev),
    .o_lk_done(done), .o_lk_paddr(pa), .o_lk_isi(isi), .o_lk_dsi(dsi),
    .o_lk_cache_inhibit(ci), .o_lk_write_thru(wt), .o_lk_guarded(gd),
    .o_lk_spec_block(sb), .o_irq(irq));

  // Second build: page number unused, write-through bit chooses the policy
  tlw_top #(.translation_mode_param(1), .writeback_cache_param(1'b1)) dut_wb_u (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_avs_address(adr),
    .i_avs_read(rd_q), .i_avs_write(wr_q), .i_avs_writedata(wdat),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdat2), .o_avs_waitrequest(),
    .i_lk_valid(lv), .i_lk_kind(lk), .i_lk_spec(ls), .i_lk_user(lu),
    .i_lk_vaddr(lva), .i_lk_entry(le), .i_lk_size(lsz), .i_lk_entry_valid(lev),
    .o_lk_done(), .o_lk_paddr(pa2), .o_lk_isi(), .o_lk_dsi(),
    .o_lk_cache_inhibit(), .o_lk_write_thru(wt2), .o_lk_guarded(),
    .o_lk_spec_block(), .o_irq());

  tlw_pipe_model #(.IDX_W(6)) pm_u (.i_mclk(i_mclk), .o_lk_valid(lv),
    .o_lk_kind(lk), .o_lk_spec(ls), .o_lk_user(lu), .o_lk_vaddr(lva),
    .o_lk_entry(le), .o_lk_size(lsz), .o_lk_entry_valid(lev));

  // Galois shift register keeps the random run repeatable
  function automatic logic [31:0] rnd();
    seed = (seed >> 1) ^ (seed[0] ? 32'h8020_0003 : 32'h0000_0000);
    return seed;
  endfunction

  // Page bits above the offset, offset bits from the virtual address
  function automatic logic [31:0] exp_pa(logic [31:0] w, va, logic [2:0] sz);
    logic [31:0] m;
    m = 32'hFFFF_FFFF << (SIZE_BASE_SHIFT + SIZE_STEP_SHIFT * sz);
    return (w & m) | (va & ~m);
  endfunction

  // Returns {instruction fault, data fault, speculation refused}
  function automatic logic [2:0] exp_flt(logic [31:0] w, logic [1:0] z, kd,
                                         logic u, ev, sp);
    logic deny, ex, wr;
    deny = !ev || (u && z == ZONE_CODE_00);
    ex = (u ? z == ZONE_CODE_11 : z[1]) || w[EXEC_BIT];
    wr = (u ? z == ZONE_CODE_11 : z[1]) || w[WRITE_BIT];
    return {kd == KIND_FETCH && (deny || !ex),
            kd != KIND_FETCH && (deny || (kd == KIND_STORE && !wr)),
            sp && w[GUARD_BIT]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon access; request held until waitrequest is sampled low, however
  // long that takes: only the watchdog ends a hung wait
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    adr  <= a;
    wdat <= d;
    rd_q <= !w;
    wr_q <= w;
    do
      @(posedge i_mclk);
    while (wait_q !== 1'b0);
    r = rdat;
    rd_q <= 1'b0;
    wr_q <= 1'b0;
    @(posedge i_mclk);
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog sized well past the whole sequence
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    fails++;
    conclude();
  end

  initial
  begin
    logic [31:0] r, w, zr, va;
    logic [5:0]  e;
    logic [2:0]  sz, f;
    logic [1:0]  kd;
    logic        u, ev, sp;
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    // Configuration-load contents and reset values of the zone and interrupt registers
    bus(1'b1, OFS_INDEX, 32'h0000_0005, r);
    bus(1'b0, OFS_LOW_WORD, 32'h0, r);
    check(r, ENTRY_INIT | WTHRU_MASK);
    check(rdat2, ENTRY_INIT);
    for (int i = 2; i < 7; i++)
    begin
      bus(1'b0, 5'(i * 4), 32'h0, r);
      check(r, ZERO_WORD);
    end
    // Entry survives a reset; index resets to zero, coherence reads zero
    bus(1'b1, OFS_INDEX, 32'h0000_0009, r);
    bus(1'b1, OFS_LOW_WORD, 32'hFFFF_FFFF, r);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    bus(1'b0, OFS_INDEX, 32'h0, r);
    check(r, ZERO_WORD);
    bus(1'b1, OFS_INDEX, 32'h0000_0009, r);
    bus(1'b0, OFS_LOW_WORD, 32'h0, r);
    check(r, 32'hFFFF_FFFF & ~COHERENT_MASK);
    $display("test done: reset and register values");
    // Random entries, zones and lookups; zone code and mode walk all cases
    for (int i = 0; i < 48; i++)
    begin
      e = 6'(16 + rnd() % 16);
      sz = 3'(rnd());
      // Software keeps page number bits below the page offset at zero
      w = rnd() & ((32'hFFFF_FFFF << (SIZE_BASE_SHIFT + SIZE_STEP_SHIFT * sz))
                   | 32'h0000_03FF);
      zr = rnd();
      r = rnd();
      zr[31 - 2 * w[ZONE_MSB:ZONE_LSB] -: 2] = 2'(i);
      bus(1'b1, OFS_INDEX, {26'h0, e}, r);
      bus(1'b1, OFS_LOW_WORD, w, r);
      bus(1'b1, OFS_ZONE, zr, r);
      bus(1'b0, OFS_LOW_WORD, 32'h0, r);
      check(r, (w & ~COHERENT_MASK) | WTHRU_MASK);
      check(rdat2, w & ~COHERENT_MASK);
      kd = 2'(rnd() % 3);
      u = i[2];
      ev = (i % 7) != 3;
      sp = 1'(rnd());
      va = rnd();
      pm_u.lookup(kd, sp, u, va, e, sz, ev);
      check(done, 1'b1);
      check(pa, exp_pa(w, va, sz));
      f = exp_flt(w, 2'(i), kd, u, ev, sp);
      check({isi, dsi, sb}, f);
      check({ci, wt, gd}, {w[INHIBIT_BIT], 1'b1, w[GUARD_BIT]});
      check(pa2, va);
      check(wt2, w[WTHRU_BIT]);
      @(posedge i_mclk);
    end
    $display("test done: random lookups");
    // Interrupt: raise, read, clear, then mask
    bus(1'b1, OFS_IRQ_CLR, 32'h0000_000F, r);
    bus(1'b1, OFS_IRQ_EN, 32'h0000_0001, r);
    bus(1'b1, OFS_INDEX, 32'h0000_0009, r);
    bus(1'b1, OFS_LOW_WORD, 32'h0000_0000, r);
    bus(1'b1, OFS_ZONE, 32'h0000_0000, r);
    pm_u.lookup(KIND_FETCH, 1'b0, 1'b0, 32'h1234_5678, 6'd9, 3'h1, 1'b1);
    check(isi, 1'b1);
    @(posedge i_mclk);
    bus(1'b0, OFS_IRQ_STAT, 32'h0, r);
    check(r, 32'h0000_0001);
    check(irq, 1'b1);
    bus(1'b1, OFS_IRQ_CLR, 32'h0000_0001, r);
    check(irq, 1'b0);
    pm_u.lookup(KIND_STORE, 1'b0, 1'b0, 32'h0000_0400, 6'd9, 3'h0, 1'b1);
    check(dsi, 1'b1);
    @(posedge i_mclk);
    check(irq, 1'b0);
    bus(1'b0, OFS_IRQ_STAT, 32'h0, r);
    check(r, 32'h0000_0002);
    $display("test done: interrupt");
    conclude();
  end
endmodule
